// File: logic/cap_carrier_if.sv
`timescale 1ns/1ps
`default_nettype none
// Loadable identity fields, kept by the loader and read by the bank
interface cap_fields_if;
  import cap_pkg::*;
  half_t asmType;   // Assembly type field
  half_t asmVendor; // Assembly vendor field
  half_t asmRev;    // Assembly revision field
  logic loadLocked; // Boot loading finished
  modport loader (output asmType, asmVendor, asmRev, loadLocked);
  modport reader (input asmType, asmVendor, asmRev, loadLocked);
endinterface

// Classification of the request on the port
interface req_class_if;
  import cap_pkg::*;
  logic isLocal;   // Maintenance packet for this device
  logic isRead;    // Local read request
  logic isWrite;   // Local write request
  logic badOp;     // Unknown transaction or misaligned offset
  regsel_t sel;    // Register addressed
  byte_t fwdHop;   // Hop count to pass on
  modport decoder (output isLocal, isRead, isWrite, badOp, sel, fwdHop);
  modport user (input isLocal, isRead, isWrite, badOp, sel, fwdHop);
endinterface
`default_nettype wire

// File: logic/cap_pkg.sv
// Behaviour
// RL1: Silicon step in bits 24-27; rest zero
// RL2: Metal step in bits 28-31, value undefined
// RL3: Assembly type bits 0-15, loaded from EEPROM
// RL4: Assembly vendor bits 16-31, loaded from EEPROM
// RL5: Feature list pointer reads fixed 0x0100
// RL6: Switch flag reads 1; local maintenance routed
// RL7: Bridge flag reads 0
// RL8: Endpoint flag reads 0
// RL9: Processor flag reads 0
// RL10: Registers 32-bit, read-only, bit 0 MSB
// RL11: Maintenance reads answered with register contents
// RL12: Boot loader may override loadable fields
// RL13: Writes complete ok, change nothing
`default_nettype none
package cap_pkg;
  typedef logic [31:0] word_t;   // One register word
  typedef logic [15:0] half_t;   // One half-word field
  typedef logic [3:0] nib_t;     // Four-bit field or code
  typedef logic [7:0] byte_t;    // Hop count or tag
  typedef logic [20:0] offset_t; // Byte offset in config space

  // Big-endian bit number to vector index (bit 0 is the MSB)
  function automatic int beBit(input int k);
    return 31 - k;
  endfunction

  // Register offsets
  localparam offset_t OFS_DEV_STEP = 21'h0_0004;
  localparam offset_t OFS_ASM_ID = 21'h0_0008;
  localparam offset_t OFS_ASM_INFO = 21'h0_000c;
  localparam offset_t OFS_FEATURES = 21'h0_0010;

  // Field positions, as vector index of the field's low bit
  localparam int SILICON_LO = beBit(27);
  localparam int METAL_LO = beBit(31);
  localparam int ASM_TYPE_LO = beBit(15);
  localparam int ASM_VENDOR_LO = beBit(31);
  localparam int ASM_REV_LO = beBit(15);
  localparam int FEAT_PTR_LO = beBit(31);
  localparam int BRIDGE_BIT = beBit(0);
  localparam int ENDPOINT_BIT = beBit(1);
  localparam int PROCESSOR_BIT = beBit(2);
  localparam int SWITCH_BIT = beBit(3);

  // Reset and fixed values
  localparam nib_t SILICON_STEP_RST = 4'h0;
  localparam nib_t METAL_STEP_RST = 4'h0;
  // Loadable fields before boot loading; values are arbitrary
  localparam half_t ASM_TYPE_RST = 16'h5a5a;
  localparam half_t ASM_VENDOR_RST = 16'h0a5a;
  localparam half_t ASM_REV_RST = 16'h0003;
  localparam half_t FEAT_PTR_VAL = 16'h0100;
  localparam logic BRIDGE_VAL = 1'b0;
  localparam logic ENDPOINT_VAL = 1'b0;
  localparam logic PROCESSOR_VAL = 1'b0;
  localparam logic SWITCH_VAL = 1'b1;

  // Packet codes
  localparam nib_t FTYPE_MAINT = 4'h8;
  localparam byte_t HOP_LOCAL = 8'h00;
  localparam nib_t TTYPE_READ = 4'h0;
  localparam nib_t TTYPE_WRITE = 4'h1;
  localparam nib_t TTYPE_READ_RSP = 4'h2;
  localparam nib_t TTYPE_WRITE_RSP = 4'h3;
  localparam nib_t STATUS_DONE = 4'h0;
  localparam nib_t STATUS_ERROR = 4'h7;

  // Register selected by a request offset
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_DEV_STEP = 3'b001,
    SEL_ASM_ID = 3'b010,
    SEL_ASM_INFO = 3'b011,
    SEL_FEATURES = 3'b100
  } regsel_t;

  // Answer state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ANSWER = 1'b1
  } state_t;
endpackage
`default_nettype wire

// File: logic/field_loader.sv
`timescale 1ns/1ps
`default_nettype none
module field_loader #(
  parameter cap_pkg::half_t TypeRst = cap_pkg::ASM_TYPE_RST,
  parameter cap_pkg::half_t VendorRst = cap_pkg::ASM_VENDOR_RST,
  parameter cap_pkg::half_t RevRst = cap_pkg::ASM_REV_RST
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic ldValid,
  input wire cap_pkg::offset_t ldOffset,
  input wire cap_pkg::word_t ldData,
  input wire logic ldDone,
  cap_fields_if.loader fields
);
  import cap_pkg::*;

  // Loader writes count only before the boot load is closed
  wire ldOpen = ldValid && !fields.loadLocked;
  wire ldId = ldOpen && (ldOffset == OFS_ASM_ID);
  wire ldInfo = ldOpen && (ldOffset == OFS_ASM_INFO);

  // Reset values, overridden by the boot loader until the lock is set
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fields.asmType <= TypeRst;
      fields.asmVendor <= VendorRst;
      fields.asmRev <= RevRst;
      fields.loadLocked <= 1'b0;
    end else if (ce) begin
      if (ldId) begin
        fields.asmType <= ldData[ASM_TYPE_LO +: 16]; // RL3 RL12
        fields.asmVendor <= ldData[ASM_VENDOR_LO +: 16]; // RL4 RL12
      end
      if (ldInfo) begin
        fields.asmRev <= ldData[ASM_REV_LO +: 16]; // RL12
      end
      if (ldDone) begin
        fields.loadLocked <= 1'b1;
      end
    end
  end
endmodule // field_loader
`default_nettype wire

// File: logic/maint_decode.sv
`timescale 1ns/1ps
`default_nettype none
module maint_decode (
  input wire cap_pkg::nib_t ftype,
  input wire cap_pkg::nib_t ttype,
  input wire cap_pkg::byte_t hopCount,
  input wire cap_pkg::offset_t offset,
  req_class_if.decoder cls
);
  import cap_pkg::*;

  // Offset to register select
  function automatic regsel_t decodeSel(input offset_t ofs);
    regsel_t s;
    s = SEL_NONE;
    if (ofs == OFS_DEV_STEP) begin
      s = SEL_DEV_STEP;
    end else if (ofs == OFS_ASM_ID) begin
      s = SEL_ASM_ID;
    end else if (ofs == OFS_ASM_INFO) begin
      s = SEL_ASM_INFO;
    end else if (ofs == OFS_FEATURES) begin
      s = SEL_FEATURES;
    end
    return s;
  endfunction

  wire isMaint = (ftype == FTYPE_MAINT); // Maintenance format
  wire misaligned = (offset[1:0] != 2'b00); // Word access only

  // Maintenance with zero hops stays on the register bus
  assign cls.isLocal = isMaint && (hopCount == HOP_LOCAL); // RL6
  assign cls.isRead = cls.isLocal && (ttype == TTYPE_READ);
  assign cls.isWrite = cls.isLocal && (ttype == TTYPE_WRITE);
  assign cls.badOp = !(cls.isRead || cls.isWrite) || misaligned;
  assign cls.sel = decodeSel(offset);
  // Maintenance packets lose one hop on the way through
  assign cls.fwdHop = isMaint ? byte_t'(hopCount - 8'h01) : hopCount;
endmodule // maint_decode
`default_nettype wire

// File: logic/switch_capability_id_registers.sv
`timescale 1ns/1ps
`default_nettype none
module switch_capability_id_registers #(
  // Silicon step of this die
  parameter cap_pkg::nib_t SiliconStep = cap_pkg::SILICON_STEP_RST,
  // Metal step; its true value is fixed by the mask set
  parameter cap_pkg::nib_t MetalStep = cap_pkg::METAL_STEP_RST,
  // Assembly type before loading; value is arbitrary
  parameter cap_pkg::half_t AsmTypeRst = cap_pkg::ASM_TYPE_RST,
  // Assembly vendor before loading; value is arbitrary
  parameter cap_pkg::half_t AsmVendorRst = cap_pkg::ASM_VENDOR_RST,
  // Assembly revision before loading; value is arbitrary
  parameter cap_pkg::half_t AsmRevRst = cap_pkg::ASM_REV_RST
) (
  // Clock, synchronous reset and freeze
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Maintenance request from the ports
  input wire logic reqValid,
  output logic reqReady,
  input wire cap_pkg::nib_t reqFtype,
  input wire cap_pkg::nib_t reqTtype,
  input wire cap_pkg::byte_t reqHopCount,
  input wire cap_pkg::offset_t reqOffset,
  input wire cap_pkg::byte_t reqTag,
  input wire cap_pkg::word_t reqWrData,
  // Answer to a local request
  output logic rspValid,
  input wire logic rspReady,
  output cap_pkg::word_t rspData,
  output cap_pkg::nib_t rspTtype,
  output cap_pkg::nib_t rspStatus,
  output cap_pkg::byte_t rspTag,
  // Notice of a packet routed onward
  output logic fwdValid,
  output cap_pkg::nib_t fwdFtype,
  output cap_pkg::byte_t fwdHopCount,
  output cap_pkg::byte_t fwdTag,
  // Boot loader writes and their lock
  input wire logic ldValid,
  input wire cap_pkg::offset_t ldOffset,
  input wire cap_pkg::word_t ldData,
  input wire logic ldDone,
  output logic loadLocked
);
  import cap_pkg::*;

  // How the bank works
  // One maintenance request at a time.
  // Local means maintenance with zero hops.
  // A local request is taken only while idle.
  // Its answer is built in the taking cycle.
  // The answer stands until the port takes it.
  // Ready returns in the cycle after that.
  // Other packets get no answer here.
  // They leave a one-cycle notice instead,
  // maintenance ones with one hop less.
  // All words are read-only.
  // Writes are dropped but answered done.
  // Other aligned offsets answer done too.
  // Unknown transactions answer with error.
  // So do misaligned offsets.
  // Words come from constants and fields.
  // State sits in answer path, notice path, loader and lock mirror.
  // Nothing else holds a value.

  // Clock enable
  // With ce low no register moves.
  // No request is taken on such an edge,
  // yet reqReady keeps its level.
  // Requesters hold until a ce-high edge.
  // Reset still acts while ce is low.

  // Shared carriers to the two helper blocks
  cap_fields_if fields ();
  req_class_if cls ();

  // Answer state and registered outputs
  state_t state_r;
  state_t state_nxt;
  word_t rspData_r;
  word_t rspData_nxt;
  nib_t rspTtype_r;
  nib_t rspTtype_nxt;
  nib_t rspStatus_r;
  nib_t rspStatus_nxt;
  byte_t rspTag_r;
  byte_t rspTag_nxt;
  logic fwdValid_r;
  nib_t fwdFtype_r;
  byte_t fwdHop_r;
  byte_t fwdTag_r;
  logic loadLocked_r;

  // Words are pure wiring of constants
  // and fields, with no register each,
  // so a loaded field shows on the next
  // read without any extra delay.
  // Register contents, built from fields
  word_t devStepWord;
  word_t asmIdWord;
  word_t asmInfoWord;
  word_t featureWord;
  word_t readWord;

  // Terms without ce; the registers that
  // use them only move on ce-high edges,
  // which keeps a frozen edge harmless.
  // Request handshake terms
  wire accept = reqValid && reqReady;
  wire acceptLocal = accept && cls.isLocal;
  wire acceptFwd = accept && !cls.isLocal;
  wire rspTaken = rspValid && rspReady;

  // Pure logic on the request lines,
  // used in the cycle of the request.
  // Request classification
  maint_decode decoder (
    .ftype(reqFtype),
    .ttype(reqTtype),
    .hopCount(reqHopCount),
    .offset(reqOffset),
    .cls(cls)
  );

  // The loader owns three fields and the lock.
  // Loads after the lock are ignored
  // until the next reset.
  // Loadable identity fields
  field_loader #(
    .TypeRst(AsmTypeRst),
    .VendorRst(AsmVendorRst),
    .RevRst(AsmRevRst)
  ) loader (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .ldValid(ldValid),
    .ldOffset(ldOffset),
    .ldData(ldData),
    .ldDone(ldDone),
    .fields(fields)
  );

  // Bit 0 of a field is the most significant.
  // Positions are converted in the package,
  // so words are built from shifted fields.
  // Stepping word; upper reserved bits stay zero
  assign devStepWord = (word_t'(SiliconStep) << SILICON_LO) // RL1
    | (word_t'(MetalStep) << METAL_LO); // RL2

  // Assembly identity from the loadable fields
  assign asmIdWord = (word_t'(fields.asmType) << ASM_TYPE_LO) // RL3
    | (word_t'(fields.asmVendor) << ASM_VENDOR_LO); // RL4

  // Assembly revision and the fixed feature list pointer
  assign asmInfoWord = (word_t'(fields.asmRev) << ASM_REV_LO)
    | (word_t'(FEAT_PTR_VAL) << FEAT_PTR_LO); // RL5

  // Only the four flags of this bank;
  // other feature bits belong elsewhere
  // and read zero from here.
  // Feature flags; bits below the flags read zero
  assign featureWord = (word_t'(BRIDGE_VAL) << BRIDGE_BIT) // RL7
    | (word_t'(ENDPOINT_VAL) << ENDPOINT_BIT) // RL8
    | (word_t'(PROCESSOR_VAL) << PROCESSOR_BIT) // RL9
    | (word_t'(SWITCH_VAL) << SWITCH_BIT); // RL6

  // Misaligned offsets never reach this word:
  // the decoder flags them as bad first.
  // Read mux; unmapped offsets return zero
  assign readWord = (cls.sel == SEL_DEV_STEP) ? devStepWord // RL10
    : (cls.sel == SEL_ASM_ID) ? asmIdWord
    : (cls.sel == SEL_ASM_INFO) ? asmInfoWord
    : (cls.sel == SEL_FEATURES) ? featureWord
    : 32'h0000_0000;

  // Ready is combinational from the state
  // and drops after a local request is taken.
  // One request at a time; a new one waits until the answer is taken
  assign reqReady = (state_r == ST_IDLE);

  // Answer contents keep their value while idle,
  // so the last answer stays until replaced.
  // Error answers carry zero data and the
  // write response type for writes, else the read one.
  // Answer state machine and next answer contents
  always_comb begin
    state_nxt = state_r;
    rspData_nxt = rspData_r;
    rspTtype_nxt = rspTtype_r;
    rspStatus_nxt = rspStatus_r;
    rspTag_nxt = rspTag_r;
    case (state_r)
      ST_IDLE: begin
        // Local maintenance request: build its answer
        if (acceptLocal) begin
          state_nxt = ST_ANSWER;
          rspTag_nxt = reqTag;
          if (cls.badOp) begin
            // Unknown transaction or misaligned offset
            rspData_nxt = 32'h0000_0000;
            rspStatus_nxt = STATUS_ERROR;
            rspTtype_nxt = cls.isWrite ? TTYPE_WRITE_RSP : TTYPE_READ_RSP;
          end else if (cls.isRead) begin
            // Read returns the selected word
            rspData_nxt = readWord; // RL11
            rspStatus_nxt = STATUS_DONE;
            rspTtype_nxt = TTYPE_READ_RSP;
          end else begin
            // Write is acknowledged and stores nothing
            rspData_nxt = 32'h0000_0000; // RL13
            rspStatus_nxt = STATUS_DONE; // RL13
            rspTtype_nxt = TTYPE_WRITE_RSP;
          end
        end
      end
      ST_ANSWER: begin
        // Ready is low here; nothing slips in
        // Hold the answer until the port takes it
        if (rspTaken) begin
          state_nxt = ST_IDLE;
        end
      end
      // Unused code falls back to idle
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Reset wins over the clock enable;
  // every other update waits for ce.
  // Answer registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      rspData_r <= 32'h0000_0000;
      rspTtype_r <= TTYPE_READ_RSP;
      rspStatus_r <= STATUS_DONE;
      rspTag_r <= 8'h00;
    end else if (ce) begin
      state_r <= state_nxt;
      rspData_r <= rspData_nxt;
      rspTtype_r <= rspTtype_nxt;
      rspStatus_r <= rspStatus_nxt;
      rspTag_r <= rspTag_nxt;
    end
  end

  // Only fwdValid pulses; fields hold.
  // Notices may follow on every cycle.
  // One-cycle notice for packets routed on through the fabric
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fwdValid_r <= 1'b0;
      fwdFtype_r <= 4'h0;
      fwdHop_r <= 8'h00;
      fwdTag_r <= 8'h00;
    end else if (ce) begin
      fwdValid_r <= acceptFwd; // RL6
      if (acceptFwd) begin
        fwdFtype_r <= reqFtype;
        fwdHop_r <= cls.fwdHop;
        fwdTag_r <= reqTag;
      end
    end
  end

  // The lock shows one cycle after the
  // loader sets it, so two cycles after
  // ldDone is taken.
  // Boot-load status mirrored out of the loader
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      loadLocked_r <= 1'b0;
    end else if (ce) begin
      loadLocked_r <= fields.loadLocked;
    end
  end

  // All outputs but reqReady and rspValid
  // come straight from flip-flops;
  // those two are decoded from the state.
  // Outputs
  assign rspValid = (state_r == ST_ANSWER);
  assign rspData = rspData_r;
  assign rspTtype = rspTtype_r;
  assign rspStatus = rspStatus_r;
  assign rspTag = rspTag_r;
  assign fwdValid = fwdValid_r;
  assign fwdFtype = fwdFtype_r;
  assign fwdHopCount = fwdHop_r;
  assign fwdTag = fwdTag_r;
  assign loadLocked = loadLocked_r;

  // The reduction only marks the bus as used
  // Write data is never stored: the bank is read-only
  wire unusedWrData = ^reqWrData;
endmodule // switch_capability_id_registers
`default_nettype wire

// File: verification/remote_pe_model.sv
`timescale 1ns/1ps
`default_nettype none
// Remote element issuing maintenance requests and taking answers
module remote_pe_model (
  input wire logic core_clk,
  output logic reqValid,
  input wire logic reqReady,
  output cap_pkg::nib_t reqFtype,
  output cap_pkg::nib_t reqTtype,
  output cap_pkg::byte_t reqHopCount,
  output cap_pkg::offset_t reqOffset,
  output cap_pkg::byte_t reqTag,
  output cap_pkg::word_t reqWrData,
  input wire logic rspValid,
  output logic rspReady,
  input wire cap_pkg::word_t rspData,
  input wire cap_pkg::nib_t rspTtype,
  input wire cap_pkg::nib_t rspStatus,
  input wire cap_pkg::byte_t rspTag
);
  import cap_pkg::*;
  // Idle lines at time zero
  initial begin
    {reqValid, rspReady} = 2'b00;
    {reqFtype, reqTtype, reqHopCount, reqOffset, reqTag, reqWrData} = '0;
  end
  // One request; local ones wait for the answer, taken after stall cycles
  task automatic access(input nib_t ft, input nib_t tt, input byte_t hop,
      input offset_t ofs, input int stall, output word_t d, output word_t st);
    int n;
    n = 0;
    d = '0;
    st = '0;
    @(posedge core_clk);
    reqValid <= 1'b1;
    {reqFtype, reqTtype, reqHopCount, reqOffset} <= {ft, tt, hop, ofs};
    reqTag <= {ofs[5:0], tt[1:0]};
    reqWrData <= 32'hffff_ffff;
    do @(negedge core_clk); while (!reqReady && ++n < 100);
    @(posedge core_clk);
    // Released lines show the inverse, not the last value
    reqValid <= 1'b0;
    {reqFtype, reqTtype, reqHopCount, reqOffset} <= ~{ft, tt, hop, ofs};
    reqTag <= ~{ofs[5:0], tt[1:0]};
    reqWrData <= 32'h0000_0000;
    if (ft == FTYPE_MAINT && hop == HOP_LOCAL) begin
      n = 0;
      do @(negedge core_clk); while (!rspValid && ++n < 100);
      d = rspData;
      st = {16'h0000, rspTtype, rspStatus, rspTag};
      // No answer in time: a status no check expects
      if (!rspValid) begin
        st = 32'hffff_ffff;
      end
      repeat (stall) @(posedge core_clk);
      @(posedge core_clk);
      rspReady <= 1'b1;
      @(posedge core_clk);
      rspReady <= 1'b0;
    end
  endtask
endmodule // remote_pe_model
`default_nettype wire

// File: verification/switch_capability_id_registers_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the capability bank
module switch_capability_id_registers_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire cap_pkg::nib_t reqFtype,
  input wire cap_pkg::nib_t reqTtype,
  input wire cap_pkg::byte_t reqHopCount,
  input wire cap_pkg::offset_t reqOffset,
  input wire logic rspValid,
  input wire logic rspReady,
  input wire cap_pkg::word_t rspData,
  input wire cap_pkg::nib_t rspTtype,
  input wire cap_pkg::nib_t rspStatus,
  input wire logic fwdValid,
  input wire logic ldDone,
  input wire logic loadLocked
);
  import cap_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic taken = ce && reqValid && reqReady; // Request taken
  wire logic isLocal = taken && reqFtype == FTYPE_MAINT && reqHopCount == HOP_LOCAL; // For us
  wire logic rdAcc = isLocal && reqTtype == TTYPE_READ; // Local read taken
  // Local read of one offset
  sequence readOf(ofs);
    rdAcc && reqOffset == ofs;
  endsequence
  // Clean read answer
  sequence answerDone;
    rspValid && rspTtype == TTYPE_READ_RSP && rspStatus == STATUS_DONE;
  endsequence
  chk_local_answer: assert property (isLocal |=> rspValid && !fwdValid)
    else $error("local request not answered");
  chk_forward_pulse: assert property (taken && !isLocal |=> fwdValid && !rspValid)
    else $error("foreign packet not passed on");
  chk_feature_bits: assert property (readOf(OFS_FEATURES) |=>
    answerDone ##0 rspData == 32'h1000_0000) else $error("feature word wrong");
  chk_feature_pointer: assert property (readOf(OFS_ASM_INFO) |=>
    answerDone ##0 rspData[15:0] == FEAT_PTR_VAL) else $error("pointer wrong");
  chk_step_reserved: assert property (readOf(OFS_DEV_STEP) |=>
    answerDone ##0 rspData[31:8] == 24'h00_0000) else $error("reserved bits set");
  chk_write_done: assert property (isLocal && reqTtype == TTYPE_WRITE &&
    reqOffset[1:0] == 2'b00 |=> rspValid && rspTtype == TTYPE_WRITE_RSP &&
    rspStatus == STATUS_DONE) else $error("write answer wrong");
  chk_answer_holds: assert property (rspValid && !(rspReady && ce) |=>
    rspValid && $stable(rspData)) else $error("answer dropped early");
  chk_busy_refuses: assert property (rspValid |-> !reqReady)
    else $error("ready while answer waits");
  chk_lock_delay: assert property (ce && ldDone |-> ##2 loadLocked)
    else $error("load lock late");
  chk_lock_sticks: assert property (loadLocked |=> loadLocked)
    else $error("load lock fell");
endmodule // switch_capability_id_registers_checker
bind switch_capability_id_registers switch_capability_id_registers_checker chk_u (
  .core_clk, .nrst, .ce, .reqValid, .reqReady, .reqFtype, .reqTtype, .reqHopCount,
  .reqOffset, .rspValid, .rspReady, .rspData, .rspTtype, .rspStatus, .fwdValid,
  .ldDone, .loadLocked);
`default_nettype wire

// File: verification/switch_capability_id_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the capability bank
module switch_capability_id_registers_test;
  import cap_pkg::*;
  localparam nib_t SIL = 4'h1; // Silicon step under test
  localparam nib_t MET = 4'h2; // Metal step under test
  logic core_clk = 1'b0, nrst = 1'b0, ce = 1'b1;
  logic reqValid, reqReady, rspValid, rspReady, fwdValid, loadLocked;
  logic ldValid = 1'b0, ldDone = 1'b0;
  nib_t reqFtype, reqTtype, rspTtype, rspStatus, fwdFtype;
  byte_t reqHopCount, reqTag, rspTag, fwdHopCount, fwdTag;
  offset_t reqOffset, ldOffset = 21'h0_0000;
  word_t reqWrData, rspData, ldData = 32'h0000_0000;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  offset_t ofsTab[4] = '{OFS_DEV_STEP, OFS_ASM_ID, OFS_ASM_INFO, OFS_FEATURES};
  word_t expTab[4] = '{{24'h00_0000, SIL, MET}, {ASM_TYPE_RST, ASM_VENDOR_RST},
    {ASM_REV_RST, FEAT_PTR_VAL}, 32'h1000_0000};
  always #12.5 core_clk = ~core_clk;
  switch_capability_id_registers #(.SiliconStep(SIL), .MetalStep(MET)) dut_u (
    .core_clk, .nrst, .ce, .reqValid, .reqReady, .reqFtype, .reqTtype, .reqHopCount,
    .reqOffset, .reqTag, .reqWrData, .rspValid, .rspReady, .rspData, .rspTtype,
    .rspStatus, .rspTag, .fwdValid, .fwdFtype, .fwdHopCount, .fwdTag, .ldValid,
    .ldOffset, .ldData, .ldDone, .loadLocked);
  remote_pe_model pe_u (.core_clk, .reqValid, .reqReady, .reqFtype, .reqTtype,
    .reqHopCount, .reqOffset, .reqTag, .reqWrData, .rspValid, .rspReady, .rspData,
    .rspTtype, .rspStatus, .rspTag);
  // Cut a hung run short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Local access and check of data, type, status and tag echo
  task automatic op(input nib_t tt, input offset_t ofs, input int stall, input word_t expD,
      input nib_t expTt, input nib_t expSt);
    word_t d, st;
    pe_u.access(FTYPE_MAINT, tt, HOP_LOCAL, ofs, stall, d, st);
    check(d, expD);
    check(st, {16'h0000, expTt, expSt, ofs[5:0], tt[1:0]});
  endtask
  task automatic rd(input offset_t ofs, input word_t expD);
    op(TTYPE_READ, ofs, 0, expD, TTYPE_READ_RSP, STATUS_DONE);
  endtask
  // Boot loader word
  task automatic ld(input offset_t ofs, input word_t dat);
    @(posedge core_clk);
    {ldValid, ldOffset, ldData} <= {1'b1, ofs, dat};
    @(posedge core_clk);
    {ldValid, ldData} <= {1'b0, ~dat};
  endtask
  // Foreign packet passed on as a one-cycle notice
  task automatic fw(input nib_t ft, input byte_t hop, input byte_t expHop);
    word_t d, st;
    pe_u.access(ft, TTYPE_READ, hop, OFS_FEATURES, 0, d, st);
    @(negedge core_clk);
    check({19'h0_0000, rspValid, fwdFtype, fwdHopCount}, {19'h0_0000, 1'b0, ft, expHop});
    check({31'h0000_0000, fwdValid}, 32'h0000_0001);
    check({24'h00_0000, fwdTag}, {24'h00_0000, OFS_FEATURES[5:0], TTYPE_READ[1:0]});
    @(negedge core_clk);
    check({31'h0000_0000, fwdValid}, 32'h0000_0000);
  endtask
  task automatic t_reset_values;
    for (int i = 0; i < 4; i++) begin
      rd(ofsTab[i], expTab[i]);
    end
  endtask
  // Writes answer cleanly, slow and prompt takers, nothing changes
  task automatic t_writes;
    for (int i = 0; i < 4; i++) begin
      op(TTYPE_WRITE, ofsTab[i], i, 32'h0000_0000, TTYPE_WRITE_RSP, STATUS_DONE);
    end
    t_reset_values();
  endtask
  // Reserved word and misaligned offset
  task automatic t_refused;
    op(TTYPE_READ, 21'h0_0014, 0, 32'h0000_0000, TTYPE_READ_RSP, STATUS_DONE);
    op(TTYPE_WRITE, 21'h0_0014, 1, 32'h0000_0000, TTYPE_WRITE_RSP, STATUS_DONE);
    op(TTYPE_READ, 21'h0_0011, 2, 32'h0000_0000, TTYPE_READ_RSP, STATUS_ERROR);
    op(4'h5, OFS_FEATURES, 0, 32'h0000_0000, TTYPE_READ_RSP, STATUS_ERROR);
    op(TTYPE_WRITE, 21'h0_0012, 0, 32'h0000_0000, TTYPE_WRITE_RSP, STATUS_ERROR);
  endtask
  // Reset in mid-run restores fields and reopens loading
  task automatic t_reset_again;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check({30'h0000_0000, loadLocked, rspValid}, 32'h0000_0000);
    rd(OFS_ASM_ID, expTab[1]);
    rd(OFS_ASM_INFO, expTab[2]);
  endtask
  // Clock enable low freezes loading and the lock
  task automatic t_freeze;
    @(posedge core_clk);
    ce <= 1'b0;
    ld(OFS_ASM_ID, 32'h0f0f_f0f0);
    @(posedge core_clk);
    ldDone <= 1'b1;
    @(posedge core_clk);
    ldDone <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({31'h0000_0000, loadLocked}, 32'h0000_0000);
    rd(OFS_ASM_ID, expTab[1]);
  endtask
  task automatic t_forward;
    fw(FTYPE_MAINT, 8'h03, 8'h02);
    fw(4'h5, 8'h00, 8'h00);
  endtask
  // Loaded fields show, later loads after lock are ignored
  task automatic t_loader;
    check({31'h0000_0000, loadLocked}, 32'h0000_0000);
    ld(OFS_ASM_ID, 32'h1234_5678);
    ld(OFS_ASM_INFO, 32'h0007_abcd);
    rd(OFS_ASM_ID, 32'h1234_5678);
    rd(OFS_ASM_INFO, 32'h0007_0100);
    @(posedge core_clk);
    ldDone <= 1'b1;
    @(posedge core_clk);
    ldDone <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({31'h0000_0000, loadLocked}, 32'h0000_0001);
    ld(OFS_ASM_ID, 32'h0000_0000);
    rd(OFS_ASM_ID, 32'h1234_5678);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_writes();
    t_refused();
    t_forward();
    t_loader();
    t_reset_again();
    t_freeze();
    report_and_stop();
  end
endmodule // switch_capability_id_registers_test
`default_nettype wire
